// file: design/bst_latch_if.sv
`timescale 1ns/1ps

// parallel hold stage fed from a shift path
interface bst_latch_if #(parameter int W = 3);
	logic [W-1:0] d;
	logic         load;
	logic         preset;
	logic [W-1:0] q;

	modport owner (output d, output load, output preset, input q);
	modport latch (input d, input load, input preset, output q);
endinterface

// file: design/bst_pkg.sv
package bst_pkg;

	// ------------------------------------------------------------------------
	// controller states
	// ------------------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_RESET,
		ST_IDLE,
		ST_SEL_DR,
		ST_CAP_DR,
		ST_SHIFT_DR,
		ST_EXIT1_DR,
		ST_PAUSE_DR,
		ST_EXIT2_DR,
		ST_UPD_DR,
		ST_SEL_IR,
		ST_CAP_IR,
		ST_SHIFT_IR,
		ST_EXIT1_IR,
		ST_PAUSE_IR,
		ST_EXIT2_IR,
		ST_UPD_IR
	} bst_tap_state_type;

endpackage

// file: design/bst_regs.svh
`ifndef BST_REGS_SVH
`define BST_REGS_SVH

// ----------------------------------------------------------------------------
// instruction register layout and codes
// ----------------------------------------------------------------------------
`define BST_IR_WIDTH          3
`define BST_IR_EXTEST         3'h0
`define BST_IR_SAMPLE         3'h6
`define BST_IR_BYPASS         3'h7
`define BST_IR_CAPTURE        3'h1

// ----------------------------------------------------------------------------
// reset values and crossing depth
// ----------------------------------------------------------------------------
`define BST_BYPASS_RESET      1'h0
`define BST_SYNC_STAGES       2
`define BST_TLR_HIGH_EDGES    5
`define BST_RECOVER_EDGES     3

`endif

// file: design/bst_tap_top.sv
`timescale 1ns/1ps
`include "bst_regs.svh"


module bst_tap_top #(
	parameter int NIN  = 8,
	parameter int NOUT = 8
) (
	// system clock and reset
	input  wire logic            clk,
	input  wire logic            rst,
	// scan link
	input  wire logic            scan_clock_in,
	input  wire logic            scan_mode_select,
	input  wire logic            scan_serial_in,
	output logic                 scan_serial_out,
	// input pins and their path into the core
	input  wire logic [NIN-1:0]  pad_in,
	output logic      [NIN-1:0]  core_pad_in,
	// core outputs and the output pins
	input  wire logic [NOUT-1:0] core_out,
	output logic      [NOUT-1:0] pad_out,
	// high while external test owns the output pins
	output logic                 extest_active
);
	localparam int NB  = NIN + NOUT;
	localparam int IRW = `BST_IR_WIDTH;

	if (NIN < 1 || NOUT < 1) begin : g_bad_size
		$error("boundary needs at least one input and one output cell");
	end

	// ------------------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------------------

	// boundary cells form the path only for the two boundary instructions
	function automatic logic sel_boundary(input logic [IRW-1:0] ir);
		sel_boundary = (ir == `BST_IR_EXTEST) || (ir == `BST_IR_SAMPLE);
	endfunction

	// reserved codes fall back to the bypass bit, like bypass itself
	function automatic logic sel_bypass(input logic [IRW-1:0] ir);
		sel_bypass = !sel_boundary(ir);
	endfunction

	// next state from the mode-select sample at a rising edge
	function automatic bst_pkg::bst_tap_state_type tap_next(
		input bst_pkg::bst_tap_state_type st,
		input logic                       tms
	);
		case (st)
			bst_pkg::ST_RESET:    tap_next = tms ? bst_pkg::ST_RESET  : bst_pkg::ST_IDLE;
			bst_pkg::ST_IDLE:     tap_next = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			bst_pkg::ST_SEL_DR:   tap_next = tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
			bst_pkg::ST_CAP_DR:   tap_next = tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
			bst_pkg::ST_SHIFT_DR: tap_next = tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
			bst_pkg::ST_EXIT1_DR: tap_next = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAUSE_DR;
			bst_pkg::ST_PAUSE_DR: tap_next = tms ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
			bst_pkg::ST_EXIT2_DR: tap_next = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SHIFT_DR;
			bst_pkg::ST_UPD_DR:   tap_next = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			bst_pkg::ST_SEL_IR:   tap_next = tms ? bst_pkg::ST_RESET  : bst_pkg::ST_CAP_IR;
			bst_pkg::ST_CAP_IR:   tap_next = tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
			bst_pkg::ST_SHIFT_IR: tap_next = tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
			bst_pkg::ST_EXIT1_IR: tap_next = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAUSE_IR;
			bst_pkg::ST_PAUSE_IR: tap_next = tms ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
			bst_pkg::ST_EXIT2_IR: tap_next = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SHIFT_IR;
			bst_pkg::ST_UPD_IR:   tap_next = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			default:              tap_next = bst_pkg::ST_RESET;
		endcase
	endfunction

	// ------------------------------------------------------------------------
	// state of each domain
	// ------------------------------------------------------------------------

	// scan side: reset synchroniser, controller, shift paths, serial output
	typedef struct packed {
		logic                       rst_s1;
		logic                       rst_s2;
		bst_pkg::bst_tap_state_type state;
		logic [IRW-1:0]             ir_sh;
		logic                       byp;
		logic [NB-1:0]              bsr;
		logic                       tdo;
	} bst_scan_state_type;

	// system side: pin synchroniser and the registered pin/core drive
	typedef struct packed {
		logic [NIN-1:0]  pin_s1;
		logic [NIN-1:0]  pin_s2;
		logic [NIN-1:0]  core_in;
		logic [NOUT-1:0] pad;
		logic            ext;
	} bst_sys_state_type;

	bst_scan_state_type sc_q;
	bst_scan_state_type sc_d;
	bst_sys_state_type  sy_q;
	bst_sys_state_type  sy_d;

	// scan-domain reset, from the second stage of the synchroniser only
	logic scan_rst;
	assign scan_rst = sc_q.rst_s2;

	// ------------------------------------------------------------------------
	// parallel latches on the falling scan edge
	// ------------------------------------------------------------------------

	bst_latch_if #(.W(IRW))  ir_lat ();
	bst_latch_if #(.W(NOUT)) bd_lat ();

	logic [IRW-1:0] cur_ir;
	assign cur_ir = ir_lat.q;

	// instruction: loaded in instruction update, forced to bypass in reset
	assign ir_lat.d      = sc_q.ir_sh;
	assign ir_lat.load   = (sc_q.state == bst_pkg::ST_UPD_IR);
	assign ir_lat.preset = scan_rst || (sc_q.state == bst_pkg::ST_RESET);

	// boundary output latches: only data update with the boundary selected
	assign bd_lat.d      = sc_q.bsr[NB-1:NIN];
	assign bd_lat.load   = (sc_q.state == bst_pkg::ST_UPD_DR) && sel_boundary(cur_ir);
	assign bd_lat.preset = scan_rst;

	bst_update_latch #(
		.W      (IRW),
		.PRESET (`BST_IR_BYPASS)
	) u_ir_latch (
		.scan_clk (scan_clock_in),
		.lat      (ir_lat)
	);

	bst_update_latch #(
		.W      (NOUT),
		.PRESET ({NOUT{1'b0}})
	) u_bd_latch (
		.scan_clk (scan_clock_in),
		.lat      (bd_lat)
	);

	// ------------------------------------------------------------------------
	// crossings between the two clocks
	// ------------------------------------------------------------------------

	// pin snapshot toward the scan side: core outputs above, pins below
	logic [NB-1:0] snap_scan;
	// pin control toward the system side: extest flag above, latch below
	logic [NOUT:0] ctl_sys;

	bst_word_cdc #(
		.W (NB)
	) u_snap_cdc (
		.src_clk  (clk),
		.src_rst  (rst),
		.src_data ({core_out, sy_q.pin_s2}),
		.dst_clk  (scan_clock_in),
		.dst_rst  (scan_rst),
		.dst_data (snap_scan)
	);

	bst_word_cdc #(
		.W (NOUT + 1)
	) u_ctl_cdc (
		.src_clk  (scan_clock_in),
		.src_rst  (scan_rst),
		.src_data ({cur_ir == `BST_IR_EXTEST, bd_lat.q}),
		.dst_clk  (clk),
		.dst_rst  (rst),
		.dst_data (ctl_sys)
	);

	// ------------------------------------------------------------------------
	// scan-side logic
	// ------------------------------------------------------------------------

	// registers outside the active state simply keep their contents
	always_comb begin
		sc_d        = sc_q;
		sc_d.rst_s1 = rst;
		sc_d.rst_s2 = sc_q.rst_s1;
		if (scan_rst) begin
			// power-up path; five high edges reach the same state anyway
			sc_d.state = bst_pkg::ST_RESET;
			sc_d.ir_sh = `BST_IR_BYPASS;
			sc_d.byp   = `BST_BYPASS_RESET;
			sc_d.bsr   = '0;
			sc_d.tdo   = 1'b0;
		end else begin
			sc_d.state = tap_next(sc_q.state, scan_mode_select);
			case (sc_q.state)
				bst_pkg::ST_CAP_DR: begin
					// pins land in the cells; bypass captures a fixed zero
					if (sel_boundary(cur_ir)) begin
						sc_d.bsr = snap_scan;
					end else begin
						sc_d.byp = `BST_BYPASS_RESET;
					end
				end
				bst_pkg::ST_SHIFT_DR: begin
					// shift toward the serial output, no inversion on either path
					if (sel_boundary(cur_ir)) begin
						sc_d.bsr = {scan_serial_in, sc_q.bsr[NB-1:1]};
					end else begin
						sc_d.byp = scan_serial_in;
					end
				end
				bst_pkg::ST_CAP_IR: begin
					sc_d.ir_sh = `BST_IR_CAPTURE;
				end
				bst_pkg::ST_SHIFT_IR: begin
					// all-ones input ends in the bypass code
					sc_d.ir_sh = {scan_serial_in, sc_q.ir_sh[IRW-1:1]};
				end
				default: begin
					// idle, select, exit, pause and update states hold all three shift paths; the serial output is still recomputed below
					sc_d.ir_sh = sc_q.ir_sh;
				end
			endcase
			// serial output shows the bit the next rising edge will shift out
			if (sc_d.state == bst_pkg::ST_SHIFT_IR || sc_d.state == bst_pkg::ST_EXIT1_IR) begin
				sc_d.tdo = sc_d.ir_sh[0];
			end else if (sel_boundary(cur_ir)) begin
				sc_d.tdo = sc_d.bsr[0];
			end else begin
				sc_d.tdo = sc_d.byp;
			end
		end
	end

	// every change of sc_q happens on a rising scan edge; the update latches take the falling one
	always_ff @(posedge scan_clock_in) begin
		sc_q <= sc_d;
	end

	// ------------------------------------------------------------------------
	// system-side logic
	// ------------------------------------------------------------------------

	// pins are sampled twice before use; the core never sees scanned data
	always_comb begin
		sy_d         = sy_q;
		sy_d.pin_s1  = pad_in;
		sy_d.pin_s2  = sy_q.pin_s1;
		sy_d.core_in = sy_q.pin_s2;
		sy_d.ext     = ctl_sys[NOUT];
		// the latch only moves at update edges, so the pins follow it alone
		if (ctl_sys[NOUT]) begin
			sy_d.pad = ctl_sys[NOUT-1:0];
		end else begin
			sy_d.pad = core_out;
		end
		if (rst) begin
			sy_d = '0;
		end
	end

	// the processor reset clears pin ownership; the scan side clears through its own synchroniser
	always_ff @(posedge clk) begin
		sy_q <= sy_d;
	end

	// ------------------------------------------------------------------------
	// outputs, all straight from flip-flops
	// ------------------------------------------------------------------------
	assign scan_serial_out = sc_q.tdo;
	assign core_pad_in     = sy_q.core_in;
	assign pad_out         = sy_q.pad;
	assign extest_active   = sy_q.ext;
endmodule

// file: design/bst_update_latch.sv
`timescale 1ns/1ps

// falling-edge parallel latch; preset wins over load
module bst_update_latch #(
	parameter int           W      = 3,
	parameter logic [W-1:0] PRESET = '0
) (
	// link clock
	input wire logic  scan_clk,
	// shift side and parallel output
	bst_latch_if.latch lat
);
	if (W < 1) begin : g_bad_width
		$error("latch width must be at least one");
	end

	typedef struct packed {
		logic [W-1:0] q;
	} bst_latch_state_type;

	bst_latch_state_type s_q;
	bst_latch_state_type s_d;

	// hold unless told otherwise, so the pins never move while shifting
	always_comb begin
		s_d = s_q;
		if (lat.preset) begin
			s_d.q = PRESET;
		end else if (lat.load) begin
			s_d.q = lat.d;
		end
	end

	// falling edge: the update states act half a scan period after entry
	always_ff @(negedge scan_clk) begin
		s_q <= s_d;
	end

	assign lat.q = s_q.q;
endmodule

// file: design/bst_word_cdc.sv
`timescale 1ns/1ps

// toggle handshake carrying a word between two unrelated clocks
module bst_word_cdc #(
	parameter int W = 8
) (
	// source domain
	input  wire logic         src_clk,
	input  wire logic         src_rst,
	input  wire logic [W-1:0] src_data,
	// destination domain
	input  wire logic         dst_clk,
	input  wire logic         dst_rst,
	output logic      [W-1:0] dst_data
);
	if (W < 1) begin : g_bad_width
		$error("crossing width must be at least one");
	end

	typedef struct packed {
		logic [W-1:0] data;
		logic         req;
		logic         ack_s1;
		logic         ack_s2;
	} bst_cdc_src_type;

	typedef struct packed {
		logic [W-1:0] data;
		logic         req_s1;
		logic         req_s2;
		logic         ack;
	} bst_cdc_dst_type;

	bst_cdc_src_type s_q;
	bst_cdc_src_type s_d;
	bst_cdc_dst_type d_q;
	bst_cdc_dst_type d_d;

	// source: hold the word steady until the last one was taken
	always_comb begin
		s_d        = s_q;
		s_d.ack_s1 = d_q.ack;
		s_d.ack_s2 = s_q.ack_s1;
		if (s_q.ack_s2 == s_q.req) begin
			s_d.data = src_data;
			s_d.req  = ~s_q.req;
		end
		if (src_rst) begin
			s_d = '0;
		end
	end

	always_ff @(posedge src_clk) begin
		s_q <= s_d;
	end

	// destination: the word is stable whenever req and ack differ
	always_comb begin
		d_d        = d_q;
		d_d.req_s1 = s_q.req;
		d_d.req_s2 = d_q.req_s1;
		if (d_q.req_s2 != d_q.ack) begin
			d_d.data = s_q.data;
			d_d.ack  = d_q.req_s2;
		end
		if (dst_rst) begin
			d_d = '0;
		end
	end

	// the link clock may stop; the source simply waits for the next ack
	always_ff @(posedge dst_clk) begin
		d_q <= d_d;
	end

	assign dst_data = d_q.data;
endmodule

// file: testbench/boundary_scan_tap_logic_bench.sv
`timescale 1ns/1ps
module boundary_scan_tap_logic_bench;
	logic        clk;
	logic        rst;
	logic        sck;
	logic        tms;
	logic        tdi;
	logic        tdo;
	logic [7:0]  pad_in;
	logic [7:0]  core_pad_in;
	logic [7:0]  core_out;
	logic [7:0]  pad_out;
	logic        ext;
	int          mismatches;
	int          num_checks;
	int          seed;
	logic [15:0] d;
	logic [15:0] got;
	logic [15:0] pre;
	logic [2:0]  ir;

	bst_tap_top #(.NIN(8), .NOUT(8)) uut (.clk(clk), .rst(rst), .scan_clock_in(sck),
		.scan_mode_select(tms), .scan_serial_in(tdi), .scan_serial_out(tdo),
		.pad_in(pad_in), .core_pad_in(core_pad_in), .core_out(core_out),
		.pad_out(pad_out), .extest_active(ext));
	bst_tester tst (.scan_clock_in(sck), .scan_mode_select(tms), .scan_serial_in(tdi),
		.scan_serial_out(tdo));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// scan side needs a running scan clock while reset is held
	task automatic do_reset;
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (6) @(posedge clk);
		for (int i = 0; i < 4; i++)
			tst.step(1'b1, 1'b1, got[0]);
		@(posedge clk);
		#1 rst = 1'b0;
		for (int i = 0; i < 3; i++)
			tst.step(1'b1, 1'b1, got[0]);
	endtask

	task automatic pins;
		@(posedge clk);
		#1 pad_in = 8'($random(seed));
		core_out = 8'($random(seed));
		repeat (20) @(posedge clk);
	endtask

	// crossing of the instruction has no fixed latency, so wait bounded
	task automatic wait_ext(input logic v);
		int k;
		k = 0;
		while (ext !== v && k < 60) begin
			@(posedge clk);
			k++;
		end
		if (ext !== v) begin
			mismatches++;
			wrap_up();
		end
		repeat (20) @(posedge clk);
	endtask

	// model: captured bits leave first, then the bits sent in
	task automatic scan_dr(input int n, input logic [15:0] cap, input int cl, input int pz,
		input string what);
		bit          q[$];
		logic [15:0] e;
		for (int i = 0; i < cl; i++)
			q.push_back(cap[i]);
		for (int i = 0; i < n; i++)
			q.push_back(d[i]);
		e = '0;
		for (int i = 0; i < n; i++)
			e[i] = q[i];
		d = d;
		tst.dr_scan(n, d, pz, got);
		check(what, got, e);
	endtask

	task automatic load_ir(input logic [2:0] code);
		tst.ir_scan(code, ir);
		check("ir capture", {13'h0000, ir}, 16'h0001);
	endtask

	initial begin
		seed = 32'h00fa5fa9;
		mismatches = 0;
		num_checks = 0;
		rst = 1'b1;
		pad_in = 8'h00;
		core_out = 8'h00;
		d = 16'h0000;
		do_reset();
		pins();
		d = 16'($random(seed));
		scan_dr(8, 16'h0000, 1, 0, "bypass after reset");
		$display("test reset done");
		// every code but extest and sample/preload; reserved ones fall back to bypass
		for (int c = 1; c < 8; c++) begin
			if (c != 6) begin
				load_ir(3'(c));
				d = 16'($random(seed));
				scan_dr(8, 16'h0000, 1, 0, "bypass path");
				check("extest flag", {15'h0000, ext}, 16'h0000);
			end
		end
		$display("test codes done");
		pins();
		d = 16'($random(seed));
		pre = d;
		load_ir(3'h6);
		scan_dr(16, {core_out, pad_in}, 16, 0, "sample snapshot");
		repeat (20) @(posedge clk);
		check("pads under sample", {8'h00, pad_out}, {8'h00, core_out});
		check("core pins", {8'h00, core_pad_in}, {8'h00, pad_in});
		load_ir(3'h0);
		wait_ext(1'b1);
		check("preload on pads", {8'h00, pad_out}, {8'h00, pre[15:8]});
		pins();
		d = 16'($random(seed));
		scan_dr(16, {core_out, pad_in}, 16, 9, "extest capture");
		repeat (20) @(posedge clk);
		check("extest pads", {8'h00, pad_out}, {8'h00, d[15:8]});
		$display("test extest done");
		// five highs reach reset; more edges let the bypass code cross
		for (int i = 0; i < 8; i++)
			tst.step(1'b1, 1'b1, got[0]);
		wait_ext(1'b0);
		check("pads released", {8'h00, pad_out}, {8'h00, core_out});
		for (int i = 0; i < 4; i++)
			tst.step(i != 0, 1'b1, got[0]);
		load_ir(3'h6);
		do_reset();
		d = 16'($random(seed));
		scan_dr(8, 16'h0000, 1, 0, "bypass after second reset");
		$display("test recovery done");
		wrap_up();
	end

	initial begin
		#400000;
		mismatches++;
		wrap_up();
	end
endmodule

// file: testbench/bst_tap_properties.sv
`timescale 1ns/1ps
// ----
// pin and link checks
// ----
module bst_tap_properties #(
	parameter int NIN  = 8,
	parameter int NOUT = 8
) (
	// clocks and reset
	input wire logic            clk,
	input wire logic            rst,
	input wire logic            scan_clock_in,
	// link
	input wire logic            scan_mode_select,
	input wire logic            scan_serial_in,
	input wire logic            scan_serial_out,
	// pins
	input wire logic [NIN-1:0]  pad_in,
	input wire logic [NIN-1:0]  core_pad_in,
	input wire logic [NOUT-1:0] core_out,
	input wire logic [NOUT-1:0] pad_out,
	input wire logic            extest_active
);
	logic       sck_q;
	logic [5:0] quiet_q;
	logic [2:0] hi_q;

	// cycles since the scan clock last moved; latches only move with it
	always_ff @(posedge clk) begin
		sck_q <= scan_clock_in;
		if (rst || scan_clock_in != sck_q)
			quiet_q <= 6'h00;
		else if (quiet_q != 6'h3F)
			quiet_q <= quiet_q + 6'h01;
	end

	// run of high mode-select samples, saturating
	always_ff @(posedge scan_clock_in) begin
		if (!scan_mode_select)
			hi_q <= 3'h0;
		else if (hi_q != 3'h7)
			hi_q <= hi_q + 3'h1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_core_pad;
		$stable(pad_in) [*6] |-> core_pad_in == pad_in;
	endproperty
	a_core_pad: assert property (p_core_pad) else $error("core pins not from pads");
	property p_pad_sys;
		!extest_active && !$past(extest_active) && !$past(extest_active, 2)
			&& !$past(rst) && !$past(rst, 2) |-> pad_out == $past(core_out);
	endproperty
	a_pad_sys: assert property (p_pad_sys) else $error("pads not from core");
	property p_pad_hold;
		extest_active && $past(extest_active, 2) && quiet_q > 6'h1E |-> $stable(pad_out);
	endproperty
	a_pad_hold: assert property (p_pad_hold) else $error("pads moved without update");
	property p_ext_rise;
		$rose(extest_active) |-> quiet_q < 6'h1E;
	endproperty
	a_ext_rise: assert property (p_ext_rise) else $error("extest without update");
	property p_ext_fall;
		$fell(extest_active) |-> quiet_q < 6'h1E;
	endproperty
	a_ext_fall: assert property (p_ext_fall) else $error("extest left idly");
	property p_tdo_edge;
		$changed(scan_serial_out) |-> scan_clock_in;
	endproperty
	a_tdo_edge: assert property (p_tdo_edge) else $error("serial out off edge");
	property p_tlr;
		hi_q >= 3'h5 && quiet_q > 6'h1E |-> !extest_active;
	endproperty
	a_tlr: assert property (p_tlr) else $error("five highs kept extest");
	property p_rst_rel;
		$fell(rst) |-> pad_out == '0 && core_pad_in == '0 && !extest_active;
	endproperty
	a_rst_rel: assert property (p_rst_rel) else $error("outputs not cleared");
endmodule

bind bst_tap_top bst_tap_properties #(.NIN(NIN), .NOUT(NOUT)) chk (
	.clk(clk), .rst(rst), .scan_clock_in(scan_clock_in),
	.scan_mode_select(scan_mode_select), .scan_serial_in(scan_serial_in),
	.scan_serial_out(scan_serial_out), .pad_in(pad_in), .core_pad_in(core_pad_in),
	.core_out(core_out), .pad_out(pad_out), .extest_active(extest_active));

// file: testbench/bst_tester.sv
`timescale 1ns/1ps
// board tester; its clock stands low between calls
module bst_tester (
	// toward the device
	output logic      scan_clock_in,
	output logic      scan_mode_select,
	output logic      scan_serial_in,
	// answer
	input  wire logic scan_serial_out
);
	initial begin
		scan_clock_in = 1'b0;
		scan_mode_select = 1'b1;
		scan_serial_in = 1'b1;
	end

	// one period; serial out taken just before the rising edge
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		scan_mode_select = tms;
		scan_serial_in = tdi;
		#7.5;
		tdo = scan_serial_out;
		scan_clock_in = 1'b1;
		#7.5;
		scan_clock_in = 1'b0;
	endtask

	// instruction scan from idle or reset, lsb first
	task automatic ir_scan(input logic [2:0] code, output logic [2:0] got);
		logic t;
		step(1'b0, 1'b1, t);
		step(1'b1, 1'b1, t);
		step(1'b1, 1'b1, t);
		step(1'b0, 1'b1, t);
		step(1'b0, 1'b1, t);
		for (int i = 0; i < 3; i++)
			step(i == 2, code[i], got[i]);
		step(1'b1, 1'b1, t);
		// idle edges let the new instruction cross before the clock stands
		repeat (6) step(1'b0, 1'b1, t);
		#1 scan_serial_in = 1'b1;
	endtask

	// data scan; a long pause after bit pz so the pins can be watched
	task automatic dr_scan(input int n, input logic [15:0] d, input int pz,
		output logic [15:0] got);
		logic t;
		got = '0;
		// idle edges first, so the pin snapshot is fresh at capture
		repeat (6) step(1'b0, 1'b1, t);
		step(1'b1, 1'b1, t);
		step(1'b0, 1'b1, t);
		step(1'b0, 1'b1, t);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1 || i == pz - 1, d[i], got[i]);
			if (i == pz - 1 && i != n - 1) begin
				step(1'b0, 1'b1, t);
				step(1'b0, 1'b1, t);
				#200;
				step(1'b1, 1'b1, t);
				step(1'b0, 1'b1, t);
			end
		end
		step(1'b1, 1'b1, t);
		// idle edges carry the updated latch across before the clock stands
		repeat (6) step(1'b0, 1'b1, t);
		#1 scan_serial_in = 1'b1;
	endtask
endmodule
